// ===== fsbr_pkg.sv
// Package for the synchronous burst-read port: register map, fields, timing.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package fsbr_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WORDS = 8'h08;

  // Config fields
  localparam int unsigned CFG_WAIT_LSB = 0;
  localparam int unsigned CFG_WRAP_BIT = 4;
  localparam int unsigned CFG_RDYT_BIT = 5;
  localparam logic [2:0] WAIT_MIN = 3'h2;
  localparam logic [2:0] WAIT_MAX = 3'h7;
  localparam logic [5:0] CONFIG_RESET = 6'h05;

  // Sleep timing: access time plus margin, in ns, then in cycles (round up)
  localparam int unsigned ASYNC_ACCESS_TIME_NS = 80;
  localparam int unsigned SLEEP_MARGIN_NS = 20;
  localparam int unsigned SLEEP_CYCLES =
    ((ASYNC_ACCESS_TIME_NS + SLEEP_MARGIN_NS) * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSBR_IDLE = 2'h0,
    FSBR_WAIT = 2'h1,
    FSBR_BURST = 2'h3
  } fsbr_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsbr_word_type;

endpackage

// ===== fsbr_port.sv
// Synchronous burst-read port of a burst-mode NOR flash, device side.
// Host strobes and address are sampled through two flops, data_taken is not; data source is an internal ROM.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module fsbr_port
  import fsbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [ADDR_W-1:0] address,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic ready,
  output logic data_valid,
  output logic sleeping,
  input wire logic data_taken,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] ce_sync, oe_sync, avd_sync;
  logic [ADDR_W-1:0] addr_meta, addr_sync;
  logic avd_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ce_sync <= 2'h3;
      oe_sync <= 2'h3;
      avd_sync <= 2'h3;
      avd_prev <= 1'b0;
      addr_meta <= '0;
      addr_sync <= '0;
    end else begin
      ce_sync <= {ce_sync[0], chip_enable_n};
      oe_sync <= {oe_sync[0], output_enable_n};
      avd_sync <= {avd_sync[0], address_valid_strobe_n};
      avd_prev <= ~avd_sync[1];
      addr_meta <= address;
      addr_sync <= addr_meta;
    end
  end
  wire logic ce_on = ~ce_sync[1];
  wire logic avd_on = ~avd_sync[1];
  // Idle strobe is high, so no false start follows reset
  wire logic avd_start = avd_on && !avd_prev;
  wire logic flush = !ce_on || avd_start;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [5:0] config_reg, next_config_reg;
  logic [15:0] word_count, next_word_count;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid_q, next_bvalid_q, rvalid_q, next_rvalid_q;
  logic [31:0] rdata_q, next_rdata_q;
  logic [1:0] bresp_q, next_bresp_q, rresp_q, next_rresp_q;
  logic word_push;

  wire logic [2:0] cfg_wait = config_reg[CFG_WAIT_LSB +: 3];
  wire logic cfg_wrap = config_reg[CFG_WRAP_BIT];
  wire logic cfg_rdyt = config_reg[CFG_RDYT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine
  fsbr_state_type state, next_state;
  logic [ADDR_W-1:0] burst_addr, next_burst_addr;
  logic [3:0] delay, next_delay;
  logic [7:0] idle_cnt, next_idle_cnt;
  logic sleep_q, next_sleep_q;
  logic [ADDR_W-1:0] last_addr, next_last_addr;
  logic buf_in_ready;

  always_comb begin
    next_state = state;
    next_burst_addr = burst_addr;
    next_delay = delay;
    word_push = 1'b0;
    if (!ce_on) begin
      next_state = FSBR_IDLE;
    end else if (avd_start) begin
      // Only the first strobe edge latches; the address may move after
      next_state = FSBR_WAIT;
      next_burst_addr = addr_sync;
      // Lower two counts unused below minimum, offsets add
      next_delay = {1'b0, cfg_wait} + {2'h0, addr_sync[1:0]} - 4'h1;
    end else begin
      unique case (state)
        FSBR_IDLE: begin
        end
        FSBR_WAIT: begin
          if (delay == 4'h0) begin
            next_state = FSBR_BURST;
          end else begin
            next_delay = delay - 4'h1;
          end
        end
        FSBR_BURST: begin
          if (buf_in_ready) begin
            word_push = 1'b1;
            if (cfg_wrap) begin
              next_burst_addr = {burst_addr[ADDR_W-1:3],
                burst_addr[2:0] + 3'h1};
            end else begin
              next_burst_addr = burst_addr + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // Auto sleep when the address stands still
  always_comb begin
    next_last_addr = addr_sync;
    next_idle_cnt = idle_cnt;
    next_sleep_q = sleep_q;
    if (addr_sync != last_addr || avd_on) begin
      next_idle_cnt = 8'h00;
      next_sleep_q = 1'b0;
    end else if (idle_cnt == 8'(SLEEP_CYCLES - 1)) begin
      next_sleep_q = 1'b1;
    end else begin
      next_idle_cnt = idle_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FSBR_IDLE;
      burst_addr <= '0;
      delay <= 4'h0;
      idle_cnt <= 8'h00;
      sleep_q <= 1'b0;
      last_addr <= '0;
    end else begin
      state <= next_state;
      burst_addr <= next_burst_addr;
      delay <= next_delay;
      idle_cnt <= next_idle_cnt;
      sleep_q <= next_sleep_q;
      last_addr <= next_last_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; a stalled receiver holds the burst, no word lost
  fsbr_word_type buf_mem [2];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] buf_cnt, next_buf_cnt;
  logic buf_pop;
  fsbr_word_type push_word;
  assign buf_in_ready = (buf_cnt != 2'h2);
  // Array contents are a function of the address; no memory model kept
  assign push_word = '{addr: burst_addr, data: burst_addr ^ 16'hA5A5};
  assign buf_pop = (buf_cnt != 2'h0) && (data_taken || !data_valid) &&
    !flush;

  always_comb begin
    next_wr_ptr = wr_ptr ^ word_push;
    next_rd_ptr = rd_ptr ^ buf_pop;
    next_buf_cnt = buf_cnt + {1'b0, word_push} - {1'b0, buf_pop};
    // A new start or a dropped chip enable discards stale words
    if (flush) begin
      next_wr_ptr = 1'b0;
      next_rd_ptr = 1'b0;
      next_buf_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      buf_cnt <= next_buf_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (word_push) begin
      buf_mem[wr_ptr] <= push_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  logic [DATA_W-1:0] next_data_out;
  logic next_data_valid, next_ready, next_data_oe;
  always_comb begin
    next_data_out = data_out;
    next_data_valid = data_valid && !data_taken && !flush;
    if (buf_pop) begin
      next_data_out = buf_mem[rd_ptr].data;
      next_data_valid = 1'b1;
    end
    // Bit clear: ready rises as a word is buffered, a cycle ahead
    next_ready = cfg_rdyt ? (buf_cnt != 2'h0) : (next_buf_cnt != 2'h0);
    next_data_oe = ce_on && !oe_sync[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_valid <= 1'b0;
      ready <= 1'b0;
      data_oe <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_valid <= next_data_valid;
      ready <= next_ready;
      data_oe <= next_data_oe;
      sleeping <= sleep_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic wr_go, rd_go;
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid_q = bvalid_q && !s_axi_bready;
    next_bresp_q = bresp_q;
    next_config_reg = config_reg;
    next_word_count = word_count + {15'h0, word_push};
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_go = aw_held && w_held && !bvalid_q;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid_q = 1'b1;
      next_bresp_q = AXI_OKAY;
      if (aw_addr == OFS_CONFIG) begin
        if (w_strb[0]) begin
          next_config_reg = w_data[5:0];
          // Out-of-range counts clamp into the legal band
          if (w_data[2:0] < WAIT_MIN) begin
            next_config_reg[2:0] = WAIT_MIN;
          end
        end
      end else if (aw_addr == OFS_WORDS) begin
        next_word_count = 16'h0000;
      end else if (aw_addr != OFS_STATUS) begin
        next_bresp_q = AXI_SLVERR;
      end
    end
    rd_go = s_axi_arvalid && !rvalid_q;
    next_rvalid_q = (rvalid_q && !s_axi_rready) || rd_go;
    next_rdata_q = rdata_q;
    next_rresp_q = rresp_q;
    if (rd_go) begin
      next_rresp_q = AXI_OKAY;
      unique case (s_axi_araddr[7:0])
        OFS_CONFIG: next_rdata_q = {26'h0, config_reg};
        OFS_STATUS: next_rdata_q = {27'h0, sleep_q, buf_cnt, state};
        OFS_WORDS: next_rdata_q = {16'h0, word_count};
        default: begin
          next_rdata_q = 32'h0;
          next_rresp_q = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= AXI_OKAY;
      config_reg <= CONFIG_RESET;
      word_count <= 16'h0000;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid_q;
      bresp_q <= next_bresp_q;
      rvalid_q <= next_rvalid_q;
      rdata_q <= next_rdata_q;
      rresp_q <= next_rresp_q;
      config_reg <= next_config_reg;
      word_count <= next_word_count;
    end
  end

  logic awready_q, wready_q, arready_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awready_q <= !next_aw_held;
      wready_q <= !next_w_held;
      arready_q <= !next_rvalid_q;
    end
  end
  // Handshake flops mirror the held flags, arready the read-valid flag, so each item is taken once
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wait_floor_a: assert property (@(posedge clk) disable iff (rst)
    config_reg[2:0] >= WAIT_MIN) else $error("wait count below two");
  start_latch_a: assert property (@(posedge clk) disable iff (rst)
    ce_on && avd_start |=> state == FSBR_WAIT &&
    burst_addr == $past(addr_sync))
    else $error("start address not latched");
  wrap_range_a: assert property (@(posedge clk) disable iff (rst)
    word_push && cfg_wrap && ce_on && !avd_on |=>
    burst_addr[ADDR_W-1:3] == $past(burst_addr[ADDR_W-1:3]))
    else $error("wrap left its range");
  linear_step_a: assert property (@(posedge clk) disable iff (rst)
    word_push && !cfg_wrap && ce_on && !avd_on |=>
    burst_addr == $past(burst_addr) + 16'h0001)
    else $error("linear step wrong");
  offset_delay_a: assert property (@(posedge clk) disable iff (rst)
    ce_on && avd_start |=> delay == $past({1'b0, cfg_wait}) +
    $past({2'h0, addr_sync[1:0]}) - 4'h1)
    else $error("offset delay wrong");
  sleep_entry_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_q) |-> idle_cnt == 8'(SLEEP_CYCLES - 1))
    else $error("sleep entered early");
  word_rate_a: assert property (@(posedge clk) disable iff (rst)
    state == FSBR_BURST && buf_cnt == 2'h0 && ce_on && !avd_on |-> word_push)
    else $error("burst word missed");
  buffer_bound_a: assert property (@(posedge clk) disable iff (rst)
    buf_cnt <= 2'h2) else $error("buffer overflow");
  cover_wrap_c: cover property (@(posedge clk) disable iff (rst)
    word_push && cfg_wrap && burst_addr[2:0] == 3'h7);
  cover_stall_c: cover property (@(posedge clk) disable iff (rst)
    buf_cnt == 2'h2 && state == FSBR_BURST);
  cover_sleep_c: cover property (@(posedge clk) disable iff (rst)
    $rose(sleep_q));

endmodule

// ===== fsbr_host.sv
// Host controller model for the burst-read port: strobes, address, taker.
// Assumes the port samples its pins on the rising edge of the shared clk.
`timescale 1ns/1ps
module fsbr_host
  import fsbr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic address_valid_strobe_n,
  output logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_valid,
  input wire logic ready,
  output logic data_taken
);
  logic stall_en = 1'b0;
  logic active = 1'b0;
  logic seen = 1'b0;
  logic rdy_prev = 1'b0;
  logic rdy_prev2 = 1'b0;
  logic rdy_lead = 1'b0;
  logic [DATA_W-1:0] words[$];
  int lat = 0;
  int tick = 0;
  initial begin
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    address = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Stalling takes two words in five, so the two-entry buffer must refuse
  always @(posedge clk) begin
    tick <= tick + 1;
    data_taken <= active && (!stall_en || (tick % 5) > 2);
    rdy_prev <= ready;
    rdy_prev2 <= rdy_prev;
    if (active && !seen) begin
      lat <= lat + 1;
    end
    if (active && data_valid && !seen) begin
      seen <= 1'b1;
      // Ready high exactly one cycle before the first word, low before that
      rdy_lead <= rdy_prev && !rdy_prev2;
    end
    if (data_valid && data_taken) begin
      words.push_back(data_out);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Address turns over while the strobe is still low: only the first edge
  // may be latched
  task automatic start(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    words.delete();
    seen <= 1'b0;
    lat <= 0;
    active <= 1'b1;
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    address_valid_strobe_n <= 1'b0;
    address <= a;
    @(posedge clk);
    address <= ~a;
    @(posedge clk);
    address_valid_strobe_n <= 1'b1;
  endtask
  task automatic stop();
    @(posedge clk);
    active <= 1'b0;
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic move(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    address <= a;
  endtask
endmodule

// ===== fsbr_port_tb_top.sv
// Self-checking bench for the burst-read port: AXI4-Lite setup, bursts.
// Assumes the host model drives the pins and records accepted words.
`timescale 1ns/1ps
module fsbr_port_tb_top
  import fsbr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce_n, oe_n, avs_n, data_oe, ready, data_valid, sleeping, taken;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] data_out;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int checks_done = 0;
  int l2, l7, l7o;
  logic [31:0] d;
  logic [1:0] r;
  initial begin
    forever #4 clk = ~clk;
  end
  fsbr_port u_fsbr_port (.clk(clk), .rst(rst), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .address_valid_strobe_n(avs_n),
    .address(address), .data_out(data_out), .data_oe(data_oe),
    .ready(ready), .data_valid(data_valid), .sleeping(sleeping),
    .data_taken(taken), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fsbr_host u_fsbr_host (.clk(clk), .rst(rst), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .address_valid_strobe_n(avs_n),
    .address(address), .data_out(data_out), .data_valid(data_valid),
    .ready(ready), .data_taken(taken));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout(input string what);
    bad_count++;
    $display("mismatch %s expected answer seen none", what);
    results();
  endtask
  // Handshakes are sampled mid-cycle, acted on at the next rising edge
  task automatic axi_write(input logic [31:0] a, input logic [31:0] v,
                           output logic [1:0] rs);
    int i;
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) timeout("write response");
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
    int i;
    logic ar_t, r_t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) timeout("read data");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Expected words follow the address walk, never the port's outputs
  task automatic burst(input logic [7:0] cfg, input logic [15:0] a,
                       input int n, input logic stall, output int lat);
    int i;
    logic [15:0] w;
    logic [1:0] rs;
    axi_write(32'h0000_0000, {24'h000000, cfg}, rs);
    check("config write resp", {30'h0, rs}, {30'h0, AXI_OKAY});
    u_fsbr_host.stall_en = stall;
    u_fsbr_host.start(a);
    for (i = 0; i < 400 && u_fsbr_host.words.size() < n; i++) begin
      @(posedge clk);
    end
    if (i == 400) timeout("burst words");
    check("output enable on", {31'h0, data_oe}, 1);
    u_fsbr_host.stop();
    check("output enable off", {31'h0, data_oe}, 0);
    for (i = 0; i < n; i++) begin
      w = cfg[4] ? ((a & 16'hFFF8) | ((a + i[15:0]) & 16'h0007))
                 : a + i[15:0];
      check("burst word", {16'h0000, u_fsbr_host.words[i]},
            {16'h0000, w ^ 16'hA5A5});
    end
    lat = u_fsbr_host.lat;
    $display("test done: burst config %h start %h", cfg, a);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    axi_read(32'h0000_0000, d, r);
    check("config reset", d, 32'h0000_0005);
    axi_read(32'h0000_000C, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, AXI_SLVERR});
    check("unmapped data", d, 32'h0000_0000);
    axi_write(32'h0000_000C, 32'h0000_0001, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, AXI_SLVERR});
    $display("test done: registers");
    // Host paces wait states to its clock rate
    burst(8'h02, 16'h0010, 12, 1'b0, l2);
    burst(8'h07, 16'h0010, 12, 1'b0, l7);
    check("ready one cycle ahead", {31'h0, u_fsbr_host.rdy_lead}, 1);
    check("wait state span", l7 - l2, 5);
    burst(8'h17, 16'h0013, 8, 1'b1, l7o);
    check("offset delay", l7o - l7, 3);
    repeat (20) @(posedge clk);
    check("asleep when stable", {31'h0, sleeping}, 1);
    u_fsbr_host.move(16'h0123);
    repeat (5) @(posedge clk);
    check("awake on change", {31'h0, sleeping}, 0);
    $display("test done: sleep");
    burst(8'h22, 16'h0010, 4, 1'b0, l2);
    check("ready with data", {31'h0, u_fsbr_host.rdy_lead}, 0);
    axi_write(32'h0000_0008, 32'h0000_0000, r);
    axi_read(32'h0000_0008, d, r);
    check("word count cleared", d, 32'h0000_0000);
    $display("test done: word count");
    results();
  end
endmodule
